// File: core/umfl_pkg.sv
// Package: register indices, field layout and reset values of the modem and FIFO level slice
package umfl_pkg;

   // Register indices on the host register port
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] ADDR_MODEM_LINE_STATUS = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_SCRATCH_BYTE = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_FLOW_THRESHOLD_CTRL = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_FIFO_IRQ_TRIGGER_LEVELS = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_TX_FREE_SPACE_COUNT = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_RX_FILL_COUNT = 4'h5;
   localparam logic [ADDR_W-1:0] ADDR_PIN_DIRECTION = 4'h6;

   // Data widths
   localparam int DATA_W = 8;
   localparam int LVL_W = 7;
   localparam int FIELD_W = 4;
   localparam int MODEM_W = 4;

   // Modem status layout: live levels in the high nibble, change flags in the low nibble
   localparam int MSR_CD_BIT = 7;
   localparam int MSR_RI_BIT = 6;
   localparam int MSR_DSR_BIT = 5;
   localparam int MSR_CTS_BIT = 4;
   localparam int MSR_LIVE_MSB = 7;
   localparam int MSR_LIVE_LSB = 4;
   localparam int MSR_DELTA_MSB = 3;
   localparam int MSR_DELTA_LSB = 0;

   // Index of each line inside the 4-bit modem vectors
   localparam int LN_CD = 3;
   localparam int LN_RI = 2;
   localparam int LN_DSR = 1;
   localparam int LN_CTS = 0;

   // Threshold and trigger field positions
   localparam int TCR_HALT_MSB = 3;
   localparam int TCR_HALT_LSB = 0;
   localparam int TCR_RESUME_MSB = 7;
   localparam int TCR_RESUME_LSB = 4;
   localparam int TLR_RX_MSB = 7;
   localparam int TLR_RX_LSB = 4;
   localparam int TLR_TX_MSB = 3;
   localparam int TLR_TX_LSB = 0;
   localparam int LVL_MSB = 6;

   // Levels are a field times four
   localparam logic [1:0] LVL_STEP_PAD = 2'h0;
   localparam logic LVL_TOP_PAD = 1'h0;
   localparam logic [FIELD_W-1:0] FIELD_ZERO = 4'h0;

   // Reset values
   localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
   localparam logic [MODEM_W-1:0] RST_MODEM_PINS = 4'hF;
   localparam logic [MODEM_W-1:0] RST_DELTA = 4'h0;
   localparam logic RST_TOP_BIT = 1'h0;

endpackage

// File: core/umfl_sync2.sv
// Two-stage synchroniser for the active-low modem input pins
`timescale 1ns/1ps
module umfl_sync2 import umfl_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [MODEM_W-1:0] pin_async,
   output logic [MODEM_W-1:0] pin_sync
);

   logic [MODEM_W-1:0] meta_q;
   logic [MODEM_W-1:0] sync_q;

   // Resets to the idle high level so no change is flagged at start-up
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= RST_MODEM_PINS;
         sync_q <= RST_MODEM_PINS;
      end else begin
         meta_q <= pin_async;
         sync_q <= meta_q;
      end
   end

   assign pin_sync = sync_q;

endmodule

// File: core/umfl_regs.sv
// Modem status, scratch, flow threshold, trigger level, FIFO level and pin direction registers
//
// Contract
// - Status bit 7 reads inverted carrier detect
// - Status bit 6 reads inverted ring indicator
// - Status bit 5 reads inverted data-set-ready
// - Status bit 4 always reads inverted clear-to-send
// - Bits 3,1,0 flag changes; read clears them
// - Bit 2 flags ring pin rising; read clears
// - Pin state bits unreliable for modem pins
// - Scratch byte stores and returns host value
// - Threshold: halt in 3:0, resume in 7:4
// - Threshold field times four gives level
// - All-zero threshold falls back to FIFO control
// - Threshold and trigger writes need both enables
// - Trigger: receive in 7:4, transmit in 3:0
// - Nonzero trigger field overrides FIFO control
// - Transmit level reads free spaces, bit 7 zero
// - Receive level reads fill count, bit 7 zero
// - Direction bit n sets pin n direction
// - Pin control bit selects modem pin use
`timescale 1ns/1ps
module umfl_regs import umfl_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_wdata,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic modem_mode_en,
   input wire logic enhanced_function_en,
   input wire logic modem_control_tcr_tlr_en,
   input wire logic cd_n,
   input wire logic ri_n,
   input wire logic dsr_n,
   input wire logic cts_n,
   input wire logic [LVL_W-1:0] tx_free_spaces,
   input wire logic [LVL_W-1:0] rx_fill_level,
   input wire logic [LVL_W-1:0] fcr_rx_trig_chars,
   input wire logic [LVL_W-1:0] fcr_tx_trig_chars,
   output logic [LVL_W-1:0] rx_trig_chars,
   output logic [LVL_W-1:0] tx_trig_chars,
   output logic [LVL_W-1:0] flow_halt_chars,
   output logic [LVL_W-1:0] flow_resume_chars,
   output logic [DATA_W-1:0] pin_direction,
   output logic modem_change_pending
);

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] idx);
      return addr == idx;
   endfunction

   // A 4-bit field in steps of four, widened to a character count
   function automatic logic [LVL_W-1:0] field_to_chars(input logic [FIELD_W-1:0] f);
      return {LVL_TOP_PAD, f, LVL_STEP_PAD};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Modem inputs

   logic [MODEM_W-1:0] pins_sync;
   logic [MODEM_W-1:0] pins_prev_q;
   logic [MODEM_W-1:0] delta_q;
   logic [MODEM_W-1:0] delta_d;
   logic [MODEM_W-1:0] line_live;
   logic [MODEM_W-1:0] line_change;
   logic [MODEM_W-1:0] line_set;
   logic [MODEM_W-1:0] group_mask;

   umfl_sync2 u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .pin_async({cd_n, ri_n, dsr_n, cts_n}),
      .pin_sync(pins_sync)
   );

   // Clear-to-send is a dedicated pin; the rest only count when the group is in modem use
   assign group_mask = {modem_mode_en, modem_mode_en, modem_mode_en, 1'h1};
   assign line_live = ~pins_sync & group_mask;
   assign line_change = (pins_sync ^ pins_prev_q) & group_mask;

   // Ring flag is edge-only: the pin returning high marks the end of a ring
   assign line_set[LN_CD] = line_change[LN_CD];
   assign line_set[LN_DSR] = line_change[LN_DSR];
   assign line_set[LN_CTS] = line_change[LN_CTS];
   assign line_set[LN_RI] = modem_mode_en && !pins_prev_q[LN_RI] && pins_sync[LN_RI];

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Decode

   logic rd_msr;
   logic wr_scratch;
   logic wr_gate;
   logic wr_tcr;
   logic wr_tlr;
   logic wr_dir;

   assign rd_msr = reg_rd && addr_hit(reg_addr, ADDR_MODEM_LINE_STATUS);
   assign wr_scratch = reg_wr && addr_hit(reg_addr, ADDR_SCRATCH_BYTE);
   assign wr_gate = enhanced_function_en && modem_control_tcr_tlr_en;
   assign wr_tcr = reg_wr && wr_gate && addr_hit(reg_addr, ADDR_FLOW_THRESHOLD_CTRL);
   assign wr_tlr = reg_wr && wr_gate && addr_hit(reg_addr, ADDR_FIFO_IRQ_TRIGGER_LEVELS);
   assign wr_dir = reg_wr && addr_hit(reg_addr, ADDR_PIN_DIRECTION);

   // A fresh change in the clearing cycle survives the read
   assign delta_d = (rd_msr ? RST_DELTA : delta_q) | line_set;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Storage

   logic [DATA_W-1:0] scratch_q;
   logic [DATA_W-1:0] tcr_q;
   logic [DATA_W-1:0] tlr_q;
   logic [DATA_W-1:0] dir_q;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pins_prev_q <= RST_MODEM_PINS;
         delta_q <= RST_DELTA;
      end else begin
         pins_prev_q <= pins_sync;
         delta_q <= delta_d;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         scratch_q <= RST_BYTE;
      end else if (wr_scratch) begin
         scratch_q <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tcr_q <= RST_BYTE;
      end else if (wr_tcr) begin
         tcr_q <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tlr_q <= RST_BYTE;
      end else if (wr_tlr) begin
         tlr_q <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dir_q <= RST_BYTE;
      end else if (wr_dir) begin
         dir_q <= reg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Read path

   logic [DATA_W-1:0] msr_val;
   logic [DATA_W-1:0] tx_free_space_count_val;
   logic [DATA_W-1:0] rx_fill_count_val;

   // Modem pins are read here, never through the general pin state
   // Flags left over from modem use stay hidden from the status read once the group is plain pins, but still drive modem_change_pending
   assign msr_val = {line_live, delta_q & group_mask};
   assign tx_free_space_count_val = {RST_TOP_BIT, tx_free_spaces};
   assign rx_fill_count_val = {RST_TOP_BIT, rx_fill_level};

   assign rdata_d = addr_hit(reg_addr, ADDR_MODEM_LINE_STATUS) ? msr_val :
                    addr_hit(reg_addr, ADDR_SCRATCH_BYTE) ? scratch_q :
                    addr_hit(reg_addr, ADDR_FLOW_THRESHOLD_CTRL) ? tcr_q :
                    addr_hit(reg_addr, ADDR_FIFO_IRQ_TRIGGER_LEVELS) ? tlr_q :
                    addr_hit(reg_addr, ADDR_TX_FREE_SPACE_COUNT) ? tx_free_space_count_val :
                    addr_hit(reg_addr, ADDR_RX_FILL_COUNT) ? rx_fill_count_val :
                    addr_hit(reg_addr, ADDR_PIN_DIRECTION) ? dir_q : RST_BYTE;

   // Read data is held until the next read so a slow host port can shift it out
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= RST_BYTE;
      end else if (reg_rd) begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Level selection

   logic [FIELD_W-1:0] tlr_rx_f;
   logic [FIELD_W-1:0] tlr_tx_f;
   logic tcr_zero;

   assign tlr_rx_f = tlr_q[TLR_RX_MSB:TLR_RX_LSB];
   assign tlr_tx_f = tlr_q[TLR_TX_MSB:TLR_TX_LSB];
   assign tcr_zero = tcr_q == RST_BYTE;

   // Each direction falls back on its own
   assign rx_trig_chars = (tlr_rx_f != FIELD_ZERO) ? field_to_chars(tlr_rx_f) : fcr_rx_trig_chars;
   assign tx_trig_chars = (tlr_tx_f != FIELD_ZERO) ? field_to_chars(tlr_tx_f) : fcr_tx_trig_chars;

   // No halt-above-resume check here; software owns that ordering
   assign flow_halt_chars = tcr_zero ? fcr_rx_trig_chars :
                            field_to_chars(tcr_q[TCR_HALT_MSB:TCR_HALT_LSB]);
   assign flow_resume_chars = tcr_zero ? fcr_rx_trig_chars :
                              field_to_chars(tcr_q[TCR_RESUME_MSB:TCR_RESUME_LSB]);

   assign pin_direction = dir_q;
   assign modem_change_pending = |delta_q;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   property p_cd_read;
      (rd_msr && modem_mode_en) |=> reg_rdata[MSR_CD_BIT] == !$past(pins_sync[LN_CD]);
   endproperty
   a_cd_read: assert property (p_cd_read) else $error("carrier detect bit not inverted pin");

   property p_ri_read;
      (rd_msr && modem_mode_en) |=> reg_rdata[MSR_RI_BIT] == !$past(pins_sync[LN_RI]);
   endproperty
   a_ri_read: assert property (p_ri_read) else $error("ring bit not inverted pin");

   property p_dsr_off;
      (rd_msr && !modem_mode_en) |=> reg_rdata[MSR_DSR_BIT] == 1'h0 &&
         reg_rdata[MSR_DELTA_LSB + LN_DSR] == 1'h0 && !delta_q[LN_DSR];
   endproperty
   a_dsr_off: assert property (p_dsr_off) else $error("data-set-ready shown outside modem use");

   property p_cts_read;
      rd_msr |=> reg_rdata[MSR_CTS_BIT] == !$past(pins_sync[LN_CTS]);
   endproperty
   a_cts_read: assert property (p_cts_read) else $error("clear-to-send bit not inverted pin");

   property p_cts_flag;
      $changed(pins_sync[LN_CTS]) ##1 !rd_msr |=> delta_q[LN_CTS];
   endproperty
   a_cts_flag: assert property (p_cts_flag) else $error("clear-to-send change not flagged");

   property p_ri_fall_no_flag;
      (!rd_msr && !delta_q[LN_RI] && $fell(pins_sync[LN_RI])) |=> !delta_q[LN_RI];
   endproperty
   a_ri_fall_no_flag: assert property (p_ri_fall_no_flag) else $error("ring flag set on falling pin");

   property p_read_clears;
      (rd_msr && line_set == RST_DELTA) |=> delta_q == RST_DELTA;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("status read left a flag set");

   property p_set_wins;
      (rd_msr && line_set[LN_CTS]) |=> delta_q[LN_CTS];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("change lost in clearing cycle");

   property p_scratch;
      wr_scratch ##1 (reg_rd && addr_hit(reg_addr, ADDR_SCRATCH_BYTE) && !reg_wr)
         |=> reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_scratch: assert property (p_scratch) else $error("scratch byte did not return write");

   property p_tcr_gate;
      (reg_wr && !wr_gate) |=> $stable(tcr_q) && $stable(tlr_q);
   endproperty
   a_tcr_gate: assert property (p_tcr_gate) else $error("threshold write taken while locked");

   property p_halt_level;
      !tcr_zero |-> flow_halt_chars == {LVL_TOP_PAD, tcr_q[TCR_HALT_MSB:TCR_HALT_LSB], LVL_STEP_PAD};
   endproperty
   a_halt_level: assert property (p_halt_level) else $error("halt level not field times four");

   property p_fallback;
      tcr_zero |-> flow_halt_chars == fcr_rx_trig_chars && flow_resume_chars == fcr_rx_trig_chars;
   endproperty
   a_fallback: assert property (p_fallback) else $error("zero threshold did not fall back");

   property p_tlr_override;
      (tlr_tx_f != FIELD_ZERO) |-> tx_trig_chars == field_to_chars(tlr_tx_f);
   endproperty
   a_tlr_override: assert property (p_tlr_override) else $error("nonzero trigger field ignored");

   property p_lvl_top;
      (reg_rd && (addr_hit(reg_addr, ADDR_TX_FREE_SPACE_COUNT) || addr_hit(reg_addr, ADDR_RX_FILL_COUNT)))
         |=> reg_rdata[DATA_W-1] == 1'h0 && reg_rdata[LVL_MSB:0] ==
            ($past(reg_addr) == ADDR_TX_FREE_SPACE_COUNT ? $past(tx_free_spaces) : $past(rx_fill_level));
   endproperty
   a_lvl_top: assert property (p_lvl_top) else $error("level register top bit not zero");

   property p_dir;
      wr_dir |=> pin_direction == $past(reg_wdata);
   endproperty
   a_dir: assert property (p_dir) else $error("pin direction not updated");

   property p_dsr_read;
      (rd_msr && modem_mode_en) |=> reg_rdata[MSR_DSR_BIT] == !$past(pins_sync[LN_DSR]);
   endproperty
   a_dsr_read: assert property (p_dsr_read) else $error("data-set-ready bit not inverted pin");

   property p_cd_flag;
      (modem_mode_en && $changed(pins_sync[LN_CD])) |=> delta_q[LN_CD];
   endproperty
   a_cd_flag: assert property (p_cd_flag) else $error("carrier detect change not flagged");

   property p_dsr_flag;
      (modem_mode_en && $changed(pins_sync[LN_DSR])) |=> delta_q[LN_DSR];
   endproperty
   a_dsr_flag: assert property (p_dsr_flag) else $error("data-set-ready change not flagged");

   property p_ri_rise_flag;
      (modem_mode_en && $rose(pins_sync[LN_RI])) |=> delta_q[LN_RI];
   endproperty
   a_ri_rise_flag: assert property (p_ri_rise_flag) else $error("ring rising pin not flagged");

   property p_group_off;
      (rd_msr && !modem_mode_en) |=> reg_rdata[MSR_CD_BIT] == 1'h0 && reg_rdata[MSR_RI_BIT] == 1'h0;
   endproperty
   a_group_off: assert property (p_group_off) else $error("plain pin group shown as modem line");

   property p_resume_level;
      !tcr_zero |-> flow_resume_chars == {LVL_TOP_PAD, tcr_q[TCR_RESUME_MSB:TCR_RESUME_LSB], LVL_STEP_PAD};
   endproperty
   a_resume_level: assert property (p_resume_level) else $error("resume level not field times four");

   property p_rx_trig;
      (tlr_rx_f != FIELD_ZERO) |-> rx_trig_chars == {LVL_TOP_PAD, tlr_rx_f, LVL_STEP_PAD};
   endproperty
   a_rx_trig: assert property (p_rx_trig) else $error("receive trigger field ignored");

   property p_trig_fallback;
      (tlr_rx_f == FIELD_ZERO) |-> rx_trig_chars == fcr_rx_trig_chars;
   endproperty
   a_trig_fallback: assert property (p_trig_fallback) else $error("zero trigger field did not fall back");

   c_ri_edge: cover property (modem_mode_en && $rose(pins_sync[LN_RI]) ##1 delta_q[LN_RI]);
   c_set_in_read: cover property (rd_msr && |line_set);
   c_tcr_write: cover property (wr_tcr && reg_wdata != RST_BYTE);
   c_tlr_mixed: cover property (tlr_rx_f != FIELD_ZERO && tlr_tx_f == FIELD_ZERO);

endmodule

// File: tb/umfl_modem_model.sv
// Far-side model of the modem or peripheral driving the four active-low modem lines
`timescale 1ns/1ps
module umfl_modem_model import umfl_pkg::*; (
   input wire logic ref_clk,
   input wire logic [MODEM_W-1:0] line_cmd_n,
   input wire logic slow,
   output logic cd_n,
   output logic ri_n,
   output logic dsr_n,
   output logic cts_n
);
   ////////////////////////////////////////////////////////////////////////////////
   // Slow mode lags the commanded levels by two clocks, like a sluggish peripheral
   logic [MODEM_W-1:0] stage1_q = 4'hF;
   logic [MODEM_W-1:0] stage2_q = 4'hF;
   logic [MODEM_W-1:0] line_w;
   always @(posedge ref_clk) begin
      stage1_q <= line_cmd_n;
      stage2_q <= stage1_q;
   end
   assign line_w = slow ? stage2_q : line_cmd_n;
   assign cd_n = line_w[LN_CD];
   assign ri_n = line_w[LN_RI];
   assign dsr_n = line_w[LN_DSR];
   assign cts_n = line_w[LN_CTS];
endmodule

// File: tb/test_uart_modem_fifo_level_regs.sv
// Self-checking testbench of the modem status and FIFO level register slice
`timescale 1ns/1ps
module test_uart_modem_fifo_level_regs import umfl_pkg::*;;
   logic ref_clk, rst_n, reg_wr, reg_rd, modem_mode_en, enhanced_function_en, modem_control_tcr_tlr_en, slow;
   logic cd_n, ri_n, dsr_n, cts_n, modem_change_pending;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, pin_direction;
   logic [MODEM_W-1:0] line_cmd_n;
   logic [LVL_W-1:0] tx_free_spaces, rx_fill_level, fcr_rx_trig_chars, fcr_tx_trig_chars;
   logic [LVL_W-1:0] rx_trig_chars, tx_trig_chars, flow_halt_chars, flow_resume_chars;
   int checks = 0;
   int fail_count = 0;
   int cycles = 0;

   umfl_regs dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .modem_mode_en(modem_mode_en),
      .enhanced_function_en(enhanced_function_en), .modem_control_tcr_tlr_en(modem_control_tcr_tlr_en),
      .cd_n(cd_n), .ri_n(ri_n), .dsr_n(dsr_n), .cts_n(cts_n), .tx_free_spaces(tx_free_spaces),
      .rx_fill_level(rx_fill_level), .fcr_rx_trig_chars(fcr_rx_trig_chars), .fcr_tx_trig_chars(fcr_tx_trig_chars),
      .rx_trig_chars(rx_trig_chars), .tx_trig_chars(tx_trig_chars), .flow_halt_chars(flow_halt_chars),
      .flow_resume_chars(flow_resume_chars), .pin_direction(pin_direction),
      .modem_change_pending(modem_change_pending));
   umfl_modem_model modem_u (.ref_clk(ref_clk), .line_cmd_n(line_cmd_n), .slow(slow), .cd_n(cd_n),
      .ri_n(ri_n), .dsr_n(dsr_n), .cts_n(cts_n));

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
   endtask

   // Read data is looked at one falling edge after the strobe, once it has landed
   task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      chk(what, exp, reg_rdata);
   endtask

   // Write, then read the same index in the very next cycle
   task automatic wr_rd_chk(input string what, input logic [3:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      chk(what, d, reg_rdata);
   endtask

   // Pins need three edges to flag; six leaves room for the slow model's lag
   task automatic pins(input logic [3:0] v);
      line_cmd_n = v;
      repeat (6) @(negedge ref_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      for (int i = 0; i < 7; i++) begin
         rd_chk("reset read", i[3:0], 8'h00);
      end
      rd_chk("unmapped", 4'hF, 8'h00);
      chk("dir reset", 8'h00, pin_direction);
      chk("halt fallback", 8'h08, {1'b0, flow_halt_chars});
   endtask

   task automatic t_store();
      wr(ADDR_SCRATCH_BYTE, 8'hA5);
      rd_chk("scratch", ADDR_SCRATCH_BYTE, 8'hA5);
      wr_rd_chk("scratch", ADDR_SCRATCH_BYTE, 8'h5A);
      wr(ADDR_PIN_DIRECTION, 8'h81);
      chk("dir port", 8'h81, pin_direction);
      rd_chk("dir", ADDR_PIN_DIRECTION, 8'h81);
   endtask

   task automatic t_thresh();
      wr(ADDR_FLOW_THRESHOLD_CTRL, 8'h3C);
      rd_chk("gated none", ADDR_FLOW_THRESHOLD_CTRL, 8'h00);
      enhanced_function_en = 1'b1;
      wr(ADDR_FIFO_IRQ_TRIGGER_LEVELS, 8'h50);
      rd_chk("gated one", ADDR_FIFO_IRQ_TRIGGER_LEVELS, 8'h00);
      modem_control_tcr_tlr_en = 1'b1;
      // Halt above resume, loaded before any flow control is used
      wr(ADDR_FLOW_THRESHOLD_CTRL, 8'h3C);
      rd_chk("thresh", ADDR_FLOW_THRESHOLD_CTRL, 8'h3C);
      chk("halt", 8'h30, {1'b0, flow_halt_chars});
      chk("resume", 8'h0C, {1'b0, flow_resume_chars});
      wr(ADDR_FIFO_IRQ_TRIGGER_LEVELS, 8'h50);
      chk("rx trig", 8'h14, {1'b0, rx_trig_chars});
      chk("tx trig zero", 8'h10, {1'b0, tx_trig_chars});
      wr(ADDR_FIFO_IRQ_TRIGGER_LEVELS, 8'h0F);
      chk("rx trig zero", 8'h08, {1'b0, rx_trig_chars});
      chk("tx trig", 8'h3C, {1'b0, tx_trig_chars});
      wr(ADDR_FLOW_THRESHOLD_CTRL, 8'h00);
      chk("halt zero", 8'h08, {1'b0, flow_halt_chars});
      chk("resume zero", 8'h08, {1'b0, flow_resume_chars});
   endtask

   task automatic t_levels();
      tx_free_spaces = 7'h40;
      rx_fill_level = 7'h3F;
      wr(ADDR_TX_FREE_SPACE_COUNT, 8'hFF);
      rd_chk("tx level", ADDR_TX_FREE_SPACE_COUNT, 8'h40);
      rd_chk("rx level", ADDR_RX_FILL_COUNT, 8'h3F);
      tx_free_spaces = 7'h00;
      rx_fill_level = 7'h40;
      rd_chk("tx level", ADDR_TX_FREE_SPACE_COUNT, 8'h00);
      rd_chk("rx level", ADDR_RX_FILL_COUNT, 8'h40);
   endtask

   task automatic t_modem();
      modem_mode_en = 1'b1;
      line_cmd_n = 4'hE;
      @(negedge ref_clk);
      rd_chk("status race", ADDR_MODEM_LINE_STATUS, 8'h10);
      chk("pending", 8'h01, {7'h00, modem_change_pending});
      rd_chk("status cts", ADDR_MODEM_LINE_STATUS, 8'h11);
      rd_chk("status cleared", ADDR_MODEM_LINE_STATUS, 8'h10);
      chk("pending clear", 8'h00, {7'h00, modem_change_pending});
      pins(4'h4);
      rd_chk("status cd dsr", ADDR_MODEM_LINE_STATUS, 8'hBA);
      slow = 1'b1;
      pins(4'h0);
      rd_chk("status ri fall", ADDR_MODEM_LINE_STATUS, 8'hF0);
      pins(4'h4);
      rd_chk("status ri rise", ADDR_MODEM_LINE_STATUS, 8'hB4);
      modem_mode_en = 1'b0;
      pins(4'hF);
      rd_chk("status gpio", ADDR_MODEM_LINE_STATUS, 8'h01);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         give_verdict();
      end
   end

   initial begin
      rst_n = 1'b0;
      reg_addr = 4'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
      modem_mode_en = 1'b0;
      enhanced_function_en = 1'b0;
      modem_control_tcr_tlr_en = 1'b0;
      slow = 1'b0;
      line_cmd_n = 4'hF;
      tx_free_spaces = 7'h00;
      rx_fill_level = 7'h00;
      fcr_rx_trig_chars = 7'h08;
      fcr_tx_trig_chars = 7'h10;
      repeat (3) @(negedge ref_clk);
      rst_n = 1'b1;
      t_reset();
      t_store();
      t_thresh();
      t_levels();
      t_modem();
      give_verdict();
   end
endmodule
